// File: src/bzct_pkg.sv
/*
  Shared constants for the bus zone cycle timing block: zone count,
  state encodings and access lengths in system clock cycles.
  Assumes a single 50 MHz system clock domain.
*/
package bzct_pkg;

  localparam int unsigned ZONE_COUNT = 4;
  localparam int unsigned ZONE_BITS = 2;
  localparam int unsigned CNT_BITS = 2;

  // clock rate in MHz
  localparam int unsigned CLK_FREQ_MHZ = 50;

  // access lengths in clock cycles
  localparam logic [CNT_BITS-1:0] FAST_READ_CYCLES = 2'h1;
  localparam logic [CNT_BITS-1:0] NORMAL_READ_CYCLES = 2'h2;
  localparam logic [CNT_BITS-1:0] WRITE_CYCLES = 2'h2;
  localparam logic [CNT_BITS-1:0] ONE_CYCLE = 2'h1;

  // reset values
  localparam logic [ZONE_BITS-1:0] ZONE_RESET = 2'h0;

  typedef enum logic [2:0] {
    BZCT_READY  = 3'b001,
    BZCT_GAP    = 3'b010,
    BZCT_ACCESS = 3'b100
  } bzct_state_type;

endpackage

// File: src/bzct_zone_timing.sv
/*
  Per-zone bus cycle sequencer: takes one access request at a time,
  inserts idle cycles on zone changes and runs the access phase for
  the length chosen by the zone's fast read setting for reads and WRITE_CYCLES for writes.
  Assumes requests and configuration inputs are synchronous to clk_sys.
*/
// Operation
// - zone with fast read enabled finishes each read in exactly one cycle
// - zone with fast read disabled reads in at least two cycles
// - post idle set and next cycle to another zone: one idle after
// - pre idle set and new cycle to another zone: one idle before
`timescale 1ns/1ps

module bzct_zone_timing
  import bzct_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire logic [bzct_pkg::ZONE_COUNT-1:0] fastReadEnable,
  input  wire logic [bzct_pkg::ZONE_COUNT-1:0] postIdleEnable,
  input  wire logic [bzct_pkg::ZONE_COUNT-1:0] preIdleEnable,
  input  wire logic                            reqValid,
  input  wire logic [bzct_pkg::ZONE_BITS-1:0]  reqZone,
  input  wire logic                            reqWrite,
  output logic                                 reqReady_reg,
  output logic                                 busActive_reg,
  output logic                                 idleCycle_reg,
  output logic                                 busZone_reg,
  output logic [bzct_pkg::ZONE_BITS-1:0]       busZoneId_reg,
  output logic                                 busWrite_reg,
  output logic                                 done_reg
);
  import bzct_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state

  bzct_state_type        state_reg;
  bzct_state_type        state_next;
  logic [CNT_BITS-1:0]   cnt_reg;
  logic [CNT_BITS-1:0]   cnt_next;
  logic [CNT_BITS-1:0]   accLen_reg;
  logic [CNT_BITS-1:0]   accLen_next;
  logic [ZONE_BITS-1:0]  lastZone_reg;
  logic                  lastValid_reg;
  logic                  curFast_reg;
  logic                  take;
  logic                  zoneChange;
  logic                  postIdle;
  logic                  preIdle;
  logic [CNT_BITS-1:0]   gapLen;

  assign take = reqValid && reqReady_reg;
  assign zoneChange = lastValid_reg && (reqZone != lastZone_reg);
  assign postIdle = zoneChange && postIdleEnable[lastZone_reg];
  assign preIdle = zoneChange && preIdleEnable[reqZone];
  assign gapLen = {1'b0, postIdle} + {1'b0, preIdle};

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    accLen_next = accLen_reg;
    unique case (state_reg)
      BZCT_READY: begin
        if (take) begin
          if (reqWrite) begin
            accLen_next = WRITE_CYCLES;
          end else if (fastReadEnable[reqZone]) begin
            accLen_next = FAST_READ_CYCLES;
          end else begin
            accLen_next = NORMAL_READ_CYCLES;
          end
          if (gapLen != '0) begin
            state_next = BZCT_GAP;
            cnt_next = gapLen;
          end else begin
            state_next = BZCT_ACCESS;
            cnt_next = accLen_next;
          end
        end
      end
      BZCT_GAP: begin
        if (cnt_reg == ONE_CYCLE) begin
          state_next = BZCT_ACCESS;
          cnt_next = accLen_reg;
        end else begin
          cnt_next = cnt_reg - ONE_CYCLE;
        end
      end
      BZCT_ACCESS: begin
        if (cnt_reg == ONE_CYCLE) begin
          state_next = BZCT_READY;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg - ONE_CYCLE;
        end
      end
      default: begin
        state_next = BZCT_READY;
        cnt_next = '0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer registers

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BZCT_READY;
      cnt_reg <= '0;
      accLen_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      accLen_reg <= accLen_next;
    end
  end

  // zone history for change detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lastZone_reg <= ZONE_RESET;
      lastValid_reg <= 1'b0;
      curFast_reg <= 1'b0;
    end else if (take) begin
      lastZone_reg <= reqZone;
      lastValid_reg <= 1'b1;
      curFast_reg <= fastReadEnable[reqZone] && !reqWrite;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reqReady_reg <= 1'b0;
      busActive_reg <= 1'b0;
      idleCycle_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      reqReady_reg <= (state_next == BZCT_READY);
      busActive_reg <= (state_next == BZCT_ACCESS);
      idleCycle_reg <= (state_next == BZCT_GAP);
      done_reg <= (state_next == BZCT_ACCESS) && (cnt_next == ONE_CYCLE);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busZone_reg <= 1'b0;
      busZoneId_reg <= ZONE_RESET;
      busWrite_reg <= 1'b0;
    end else if (take) begin
      busZone_reg <= 1'b1;
      busZoneId_reg <= reqZone;
      busWrite_reg <= reqWrite;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  fast_read_len_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(busActive_reg) && curFast_reg |=> !busActive_reg && $past(done_reg))
    else $error("fast read not exactly one cycle");

  normal_read_len_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(busActive_reg) && !busWrite_reg && !curFast_reg |=> busActive_reg)
    else $error("normal read shorter than two cycles");

  post_idle_gap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take && postIdle |=> idleCycle_reg && !busActive_reg)
    else $error("post idle cycle missing");

  pre_idle_gap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take && preIdle && !postIdle |=> idleCycle_reg ##1 busActive_reg)
    else $error("pre idle cycle missing");

  no_idle_gap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take && !postIdle && !preIdle |=> busActive_reg && !idleCycle_reg)
    else $error("idle inserted without cause");

  two_idle_gap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take && postIdle && preIdle |=> idleCycle_reg [*2] ##1 busActive_reg)
    else $error("post and pre idle not both inserted");

  fast_done_first_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(busActive_reg) && curFast_reg |-> done_reg)
    else $error("fast read did not end in its first cycle");

  normal_no_early_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(busActive_reg) && !curFast_reg |-> !done_reg)
    else $error("normal access ended in its first cycle");

  idle_no_bus_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    idleCycle_reg |-> !busActive_reg && !reqReady_reg)
    else $error("idle cycle overlaps bus or ready");

  same_zone_gap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take && lastValid_reg && (reqZone == lastZone_reg) |=> !idleCycle_reg)
    else $error("idle inserted within one zone");

  first_access_gap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    take && !lastValid_reg |=> !idleCycle_reg && busActive_reg)
    else $error("idle inserted before first access");

  done_release_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    done_reg |=> !busActive_reg && reqReady_reg)
    else $error("bus cycle ran past its last cycle");

endmodule

// File: bench/bzct_zone_mem.sv
/*
  Zone memory model: counts idle and access cycles of each bus cycle.
  Assumes the bus outputs of bzct_zone_timing on clk_sys.
*/
`timescale 1ns/1ps

module bzct_zone_mem (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic busActive,
  input  wire logic idleCycle,
  input  wire logic done,
  output int        accLen,
  output int        gapLen
);
  int accCnt_reg;
  int gapCnt_reg;
  // counts cycles of every access, latching lengths at its end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      accCnt_reg <= 0;
      gapCnt_reg <= 0;
      accLen     <= 0;
      gapLen     <= 0;
    end else if (done === 1'b1) begin
      accLen     <= accCnt_reg + 1;
      gapLen     <= gapCnt_reg;
      accCnt_reg <= 0;
      gapCnt_reg <= 0;
    end else begin
      accCnt_reg <= accCnt_reg + (busActive === 1'b1);
      gapCnt_reg <= gapCnt_reg + (idleCycle === 1'b1);
    end
  end
endmodule

// File: bench/tb.sv
/*
  Testbench for bzct_zone_timing: timed accesses across zones.
  Assumes bzct_zone_mem measures each bus cycle.
*/
`timescale 1ns/1ps

module tb;
  import bzct_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] fastReadEnable = 4'h0, postIdleEnable = 4'h0, preIdleEnable = 4'h0;
  logic reqValid = 1'b0, reqWrite = 1'b0;
  logic [1:0] reqZone = 2'h0;
  logic reqReady_reg, busActive_reg, idleCycle_reg, done_reg;
  logic busZone_reg, busWrite_reg;
  logic [1:0] busZoneId_reg;
  int accLen, gapLen, error_cnt = 0, total_checks = 0;

  always #10 clk_sys = ~clk_sys;

  bzct_zone_timing u_bzct_zone_timing (.clk_sys(clk_sys), .rst_n(rst_n),
    .fastReadEnable(fastReadEnable), .postIdleEnable(postIdleEnable),
    .preIdleEnable(preIdleEnable),
    .reqValid(reqValid), .reqZone(reqZone), .reqWrite(reqWrite),
    .reqReady_reg(reqReady_reg), .busActive_reg(busActive_reg),
    .idleCycle_reg(idleCycle_reg), .busZone_reg(busZone_reg),
    .busZoneId_reg(busZoneId_reg), .busWrite_reg(busWrite_reg), .done_reg(done_reg));

  bzct_zone_mem u_bzct_zone_mem (.clk_sys(clk_sys), .rst_n(rst_n),
    .busActive(busActive_reg), .idleCycle(idleCycle_reg), .done(done_reg),
    .accLen(accLen), .gapLen(gapLen));

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input int exp, input int got);
    total_checks++;
    if (exp != got) begin
      $display("FAIL %s expected %0d seen %0d", nm, exp, got);
      error_cnt++;
    end
  endtask

  // one access, then compare cycle lengths and zone
  task automatic acc(input logic [1:0] z, input logic w, input int eLen, input int eGap);
    int n;
    n = 0;
    while (reqReady_reg !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (reqReady_reg !== 1'b1) begin
      $display("FAIL ready timeout expected 1 seen 0");
      error_cnt++;
      close_out();
    end
    reqValid = 1'b1;
    reqZone = z;
    reqWrite = w;
    @(posedge clk_sys);
    #1;
    reqValid = 1'b0;
    n = 0;
    while (done_reg !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (done_reg !== 1'b1) begin
      $display("FAIL done timeout expected 1 seen 0");
      error_cnt++;
      close_out();
    end
    chk("zone", 1, busZoneId_reg === z);
    chk("zone taken", 1, busZone_reg === 1'b1);
    chk("direction", 1, busWrite_reg === w);
    @(posedge clk_sys);
    #1;
    chk("access length", eLen, accLen);
    chk("idle count", eGap, gapLen);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic s_fast();
    fastReadEnable = 4'h1;
    acc(2'h0, 1'b0, 1, 0);
    acc(2'h0, 1'b0, 1, 0);
  endtask

  task automatic s_normal();
    fastReadEnable = 4'h0;
    acc(2'h0, 1'b0, 2, 0);
    acc(2'h0, 1'b1, 2, 0);
  endtask

  task automatic s_idle();
    postIdleEnable = 4'hD;
    preIdleEnable = 4'hC;
    fastReadEnable = 4'hF;
    acc(2'h1, 1'b0, 1, 1);
    acc(2'h2, 1'b0, 1, 1);
    acc(2'h3, 1'b1, 2, 2);
    acc(2'h3, 1'b0, 1, 0);
    postIdleEnable = 4'h0;
    acc(2'h1, 1'b0, 1, 0);
  endtask

  // mid-run reset: outputs clear, first access after it is no zone change
  task automatic s_reset();
    postIdleEnable = 4'hF;
    preIdleEnable = 4'hF;
    fastReadEnable = 4'h0;
    rst_n = 1'b0;
    @(posedge clk_sys);
    #1;
    chk("outputs in reset", 1, {reqReady_reg, busActive_reg, idleCycle_reg, done_reg,
      busZone_reg, busWrite_reg, busZoneId_reg} === 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk("ready at release", 1, reqReady_reg === 1'b0);
    @(posedge clk_sys);
    #1;
    chk("ready after release", 1, reqReady_reg === 1'b1);
    acc(2'h2, 1'b0, 2, 0);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    s_fast();
    s_normal();
    s_idle();
    s_reset();
    close_out();
  end
endmodule
